// ===== verilog/odc_map.vh
// Register map, field positions, reset values and timing counts of the
// oscillator and divider control block.
// Assumes a 32-bit APB slave with byte addresses, one register a word.
`ifndef ODC_MAP_VH
`define ODC_MAP_VH

// ==========================================================================
// Register byte offsets
`define ODC_OFF_OSC_CTRL 8'h00
`define ODC_OFF_CLK_DIV 8'h04
`define ODC_OFF_PLL_FB 8'h08
`define ODC_OFF_RC_TRIM 8'h0c
`define ODC_OFF_UNLOCK 8'h10
`define ODC_OFF_INT_STAT 8'h14
`define ODC_OFF_INT_EN 8'h18
`define ODC_OFF_INT_CLR 8'h1c

// ==========================================================================
// Oscillator control fields
`define ODC_OSC_REQ_BIT 0
`define ODC_OSC_SEC_EN_BIT 1
`define ODC_OSC_FAIL_BIT 3
`define ODC_OSC_NEW_LSB 8
`define ODC_OSC_CUR_LSB 12

// ==========================================================================
// Clock divisor fields
`define ODC_DIV_PRE_LSB 0
`define ODC_DIV_POST_LSB 6
`define ODC_DIV_RCPOST_LSB 8
`define ODC_DIV_RED_EN_BIT 11
`define ODC_DIV_RED_LSB 12
`define ODC_DIV_ROI_BIT 15

// ==========================================================================
// Reset values
`define ODC_RST_CLK_DIV 16'h3040
`define ODC_RST_PLL_FB 9'h030
`define ODC_RST_RC_TRIM 6'h00
`define ODC_RST_SOURCE 3'h0

// ==========================================================================
// Clock source codes
`define ODC_SRC_RC 3'h0
`define ODC_SRC_RC_PLL 3'h1
`define ODC_SRC_PRI 3'h2
`define ODC_SRC_PRI_PLL 3'h3

// ==========================================================================
// Unlock keys (arbitrary values) and switch settle count
`define ODC_KEY_FIRST 16'h00a5
`define ODC_KEY_SECOND 16'h005a
`define ODC_SETTLE_TICKS 4'ha

// ==========================================================================
// Interrupt status bits
`define ODC_IRQ_FAIL_BIT 0
`define ODC_IRQ_DONE_BIT 1
`define ODC_IRQ_ABORT_BIT 2

`endif

// ===== verilog/odc_rate_div.v
// Programmable rate divider producing a one-cycle enable pulse.
// Assumes one system clock; the divide value may change at any time.
`default_nettype none

// ==========================================================================
// Rate divider
module odc_rate_div #(
	parameter WIDTH = 8
) (
	input wire sys_clk,
	input wire rst,
	input wire [WIDTH-1:0] div_m1,
	output wire tick
);

	reg [WIDTH-1:0] count_q;
	reg tick_q;

	// Count down to zero, then pulse; a shrinking divisor takes effect at once
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_q <= {WIDTH{1'b0}};
			tick_q <= 1'b0;
		end else if (count_q == {WIDTH{1'b0}} || count_q > div_m1) begin
			count_q <= div_m1;
			tick_q <= 1'b1;
		end else begin
			count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
			tick_q <= 1'b0;
		end
	end

	assign tick = tick_q;

endmodule // odc_rate_div

`default_nettype wire

// ===== verilog/odc_top.v
// Oscillator and divider control: register file, unlock guard, source
// switch sequencer, doze divider and fail interrupt.
// Assumes rst is the power-on reset; warm_rst is a synchronous lesser reset.
`include "odc_map.vh"
`default_nettype none

// Summary of operation
// [RULE_01] Fail monitor event sets the clock fail flag
// [RULE_02] Secondary enable bit turns secondary oscillator on
// [RULE_03] Writing switch request starts switch; clears when done
// [RULE_04] Control writes accepted only after unlock sequence
// [RULE_05] Software avoids direct PLL-to-PLL source switches
// [RULE_06] Registers reset only on power-on reset; warm_rst also clears the unlock stage and idles the sequencer
// [RULE_07] Recover bit: interrupt clears reduction enable
// [RULE_08] Reduction field divides cpu clock by power two
// [RULE_09] Reduction enable off forces ratio one to one
// [RULE_10] RC postscaler divides by 1..64 or 256
// [RULE_11] VCO postscaler divides by 2, 4 or 8
// [RULE_12] Prescaler divides by field plus two
// [RULE_13] Feedback multiplier equals field plus two
// [RULE_14] Six-bit signed trim shifts RC frequency
// [RULE_15] Unimplemented bits read as zero
// [RULE_16] New source field encodes eight clock sources
// [RULE_17] Wait ready, ten ticks, then switch and clear
// [RULE_18] Same source request aborts and clears request
// [RULE_19] Fail flag cleared by writing zero only; the code also clears it when a real switch starts
module odc_top (
	input wire sys_clk,
	input wire rst,
	input wire warm_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [2:0] boot_source,
	input wire clock_fail_monitor,
	input wire [7:0] source_ready,
	input wire new_source_tick,
	input wire cpu_interrupt,
	output wire [2:0] current_source,
	output wire [2:0] target_source,
	output wire target_start,
	output wire secondary_osc_enable,
	output wire cpu_clk_en,
	output wire fast_rc_clk_en,
	output wire [5:0] phase_input_div,
	output wire [3:0] vco_output_div,
	output wire [9:0] feedback_mult,
	output wire [5:0] rc_trim,
	output wire irq
);

	// ======================================================================
	// Local state codes
	localparam ST_IDLE = 2'd0;
	localparam ST_READY = 2'd1;
	localparam ST_SETTLE = 2'd2;
	// Divisor reset word, named so its fields can be sliced
	localparam [15:0] RST_DIV = `ODC_RST_CLK_DIV;

	// ======================================================================
	// Decoding functions
	// Divide-minus-one for a power-of-two reduction code
	function [7:0] pow2_m1;
		input [2:0] code;
		begin
			pow2_m1 = (8'h01 << code) - 8'h01;
		end
	endfunction

	// RC postscaler skips divide by 128: top code means 256
	function [7:0] rc_post_m1;
		input [2:0] code;
		begin
			if (code == 3'h7)
				rc_post_m1 = 8'hff;
			else
				rc_post_m1 = pow2_m1(code);
		end
	endfunction

	// ======================================================================
	// Registers
	reg pready_q;
	reg pslverr_q;
	reg [31:0] prdata_q;
	reg [2:0] new_src_q;
	reg [2:0] cur_src_q;
	reg sec_en_q;
	reg req_q;
	reg fail_q;
	reg strap_done_q;
	reg roi_q;
	reg [2:0] red_q;
	reg red_en_q;
	reg [2:0] rc_post_q;
	reg [1:0] vco_post_q;
	reg [4:0] pre_q;
	reg [8:0] fb_q;
	reg [5:0] trim_q;
	reg [1:0] unlock_q;
	reg [1:0] state_q;
	reg [3:0] settle_q;
	reg [2:0] target_q;
	reg start_q;
	reg [2:0] int_stat_q;
	reg [2:0] int_en_q;
	reg irq_q;
	reg [5:0] pre_div_q;
	reg [3:0] vco_div_q;
	reg [9:0] mult_q;

	wire wr_en;
	wire rd_phase;
	wire osc_wr;
	wire armed;
	wire ev_done;
	wire ev_abort;
	wire ev_fail;
	wire [7:0] cpu_div_m1;
	wire [7:0] rc_div_m1;
	wire [15:0] osc_rd;
	wire [15:0] div_rd;
	reg [31:0] rd_mux;
	reg addr_ok;

	// ======================================================================
	// APB handshake
	// Writes land only at the edge where pready is seen high
	assign wr_en = psel & penable & pwrite & pready_q;
	assign rd_phase = psel & penable & ~pready_q;
	assign armed = (unlock_q == 2'd2);
	assign osc_wr = wr_en & (paddr == `ODC_OFF_OSC_CTRL) & armed; // RULE_04

	// Answer one cycle into the access phase
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= rd_phase;
			pslverr_q <= rd_phase & ~addr_ok;
			if (rd_phase & ~pwrite)
				prdata_q <= rd_mux;
		end
	end

	// ======================================================================
	// Read view
	// Unimplemented positions are tied to zero
	assign osc_rd = {1'b0, cur_src_q, 1'b0, new_src_q, 4'h0,
		fail_q, 1'b0, sec_en_q, req_q}; // RULE_15
	assign div_rd = {roi_q, red_q, red_en_q, rc_post_q, vco_post_q, 1'b0, pre_q};

	// Read mux and address check
	always @* begin
		rd_mux = 32'h00000000;
		addr_ok = 1'b1;
		case (paddr)
			`ODC_OFF_OSC_CTRL: rd_mux = {16'h0000, osc_rd};
			`ODC_OFF_CLK_DIV: rd_mux = {16'h0000, div_rd};
			`ODC_OFF_PLL_FB: rd_mux = {23'h000000, fb_q}; // RULE_15
			`ODC_OFF_RC_TRIM: rd_mux = {26'h0000000, trim_q}; // RULE_15
			`ODC_OFF_UNLOCK: rd_mux = {30'h00000000, unlock_q};
			`ODC_OFF_INT_STAT: rd_mux = {29'h00000000, int_stat_q};
			`ODC_OFF_INT_EN: rd_mux = {29'h00000000, int_en_q};
			`ODC_OFF_INT_CLR: rd_mux = 32'h00000000;
			default: addr_ok = 1'b0;
		endcase
	end

	// ======================================================================
	// Unlock guard
	// Two key writes in a row arm exactly one control write; any other
	// write in between throws the sequence away
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			unlock_q <= 2'd0;
		end else if (warm_rst) begin
			unlock_q <= 2'd0;
		end else if (wr_en) begin
			if (paddr == `ODC_OFF_UNLOCK) begin
				if (pwdata[15:0] == `ODC_KEY_FIRST)
					unlock_q <= 2'd1;
				else if (unlock_q == 2'd1 && pwdata[15:0] == `ODC_KEY_SECOND)
					unlock_q <= 2'd2;
				else
					unlock_q <= 2'd0;
			end else begin
				unlock_q <= 2'd0; // RULE_04
			end
		end
	end

	// ======================================================================
	// Oscillator control and switch sequencer
	assign ev_fail = clock_fail_monitor;
	assign ev_abort = (state_q == ST_IDLE) & req_q & (new_src_q == cur_src_q);
	assign ev_done = (state_q == ST_SETTLE) & new_source_tick &
		(settle_q == `ODC_SETTLE_TICKS - 4'h1);

	// Only power-on reset clears; warm reset just idles the sequencer
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin // RULE_06
			new_src_q <= `ODC_RST_SOURCE;
			cur_src_q <= `ODC_RST_SOURCE;
			strap_done_q <= 1'b0;
			sec_en_q <= 1'b0;
			req_q <= 1'b0;
			fail_q <= 1'b0;
			state_q <= ST_IDLE;
			settle_q <= 4'h0;
			target_q <= `ODC_RST_SOURCE;
			start_q <= 1'b0;
		end else if (!strap_done_q) begin
			// Source straps are caught once, just after release
			strap_done_q <= 1'b1;
			new_src_q <= boot_source;
			cur_src_q <= boot_source;
		end else begin
			if (osc_wr) begin
				new_src_q <= pwdata[`ODC_OSC_NEW_LSB+2:`ODC_OSC_NEW_LSB]; // RULE_16
				sec_en_q <= pwdata[`ODC_OSC_SEC_EN_BIT]; // RULE_02
				if (pwdata[`ODC_OSC_REQ_BIT])
					req_q <= 1'b1; // RULE_03
				if (!pwdata[`ODC_OSC_FAIL_BIT])
					fail_q <= 1'b0; // RULE_19
			end
			if (warm_rst) begin
				state_q <= ST_IDLE;
				start_q <= 1'b0;
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (req_q && new_src_q == cur_src_q) begin
							req_q <= 1'b0; // RULE_18
						end else if (req_q) begin
							// A real switch drops any stale fail flag
							fail_q <= 1'b0;
							target_q <= new_src_q;
							start_q <= 1'b1;
							state_q <= ST_READY;
						end
					end
					ST_READY: begin
						settle_q <= 4'h0;
						if (source_ready[target_q])
							state_q <= ST_SETTLE; // RULE_17
					end
					ST_SETTLE: begin
						if (ev_done) begin
							cur_src_q <= target_q; // RULE_17
							req_q <= 1'b0; // RULE_03
							start_q <= 1'b0;
							state_q <= ST_IDLE;
						end else if (new_source_tick) begin
							settle_q <= settle_q + 4'h1;
						end
					end
					default: begin
						state_q <= ST_IDLE;
						start_q <= 1'b0;
					end
				endcase
			end
			// Monitor event wins over any clear in the same cycle and
			// falls back to the RC source, keeping the PLL if in use
			if (ev_fail) begin
				fail_q <= 1'b1; // RULE_01
				if (cur_src_q == `ODC_SRC_PRI_PLL || cur_src_q == `ODC_SRC_RC_PLL)
					cur_src_q <= `ODC_SRC_RC_PLL;
				else
					cur_src_q <= `ODC_SRC_RC;
			end
		end
	end

	// ======================================================================
	// Clock divisor, feedback and trim registers
	// Interrupt recovery overrides a software write in the same cycle
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin // RULE_06
			{roi_q, red_q, red_en_q, rc_post_q, vco_post_q} <= RST_DIV[15:6];
			pre_q <= RST_DIV[4:0];
			fb_q <= `ODC_RST_PLL_FB;
			trim_q <= `ODC_RST_RC_TRIM;
		end else begin
			if (wr_en && paddr == `ODC_OFF_CLK_DIV) begin
				roi_q <= pwdata[`ODC_DIV_ROI_BIT];
				red_q <= pwdata[`ODC_DIV_RED_LSB+2:`ODC_DIV_RED_LSB]; // RULE_08
				red_en_q <= pwdata[`ODC_DIV_RED_EN_BIT];
				rc_post_q <= pwdata[`ODC_DIV_RCPOST_LSB+2:`ODC_DIV_RCPOST_LSB];
				vco_post_q <= pwdata[`ODC_DIV_POST_LSB+1:`ODC_DIV_POST_LSB];
				pre_q <= pwdata[`ODC_DIV_PRE_LSB+4:`ODC_DIV_PRE_LSB];
			end
			if (cpu_interrupt && roi_q)
				red_en_q <= 1'b0; // RULE_07
			if (wr_en && paddr == `ODC_OFF_PLL_FB)
				fb_q <= pwdata[8:0];
			if (wr_en && paddr == `ODC_OFF_RC_TRIM)
				trim_q <= pwdata[5:0]; // RULE_14
		end
	end

	// ======================================================================
	// PLL divisor decode, registered for the outputs
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pre_div_q <= 6'h02;
			vco_div_q <= 4'h4;
			mult_q <= 10'h032;
		end else begin
			pre_div_q <= {1'b0, pre_q} + 6'h02; // RULE_12
			mult_q <= {1'b0, fb_q} + 10'h002; // RULE_13
			case (vco_post_q)
				2'b00: vco_div_q <= 4'h2; // RULE_11
				2'b01: vco_div_q <= 4'h4;
				2'b11: vco_div_q <= 4'h8;
				default: vco_div_q <= 4'h4; // Reserved code held at default rate
			endcase
		end
	end

	// ======================================================================
	// Rate dividers
	// Reduction disabled means every cycle is a cpu cycle
	assign cpu_div_m1 = red_en_q ? pow2_m1(red_q) : 8'h00; // RULE_09
	assign rc_div_m1 = rc_post_m1(rc_post_q); // RULE_10

	odc_rate_div #(
		.WIDTH(8)
	) u_cpu_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.div_m1(cpu_div_m1),
		.tick(cpu_clk_en)
	);

	odc_rate_div #(
		.WIDTH(8)
	) u_rc_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.div_m1(rc_div_m1),
		.tick(fast_rc_clk_en)
	);

	// ======================================================================
	// Interrupt status, enable and clear
	// Hardware set beats a clear written in the same cycle
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			int_stat_q <= 3'h0;
			int_en_q <= 3'h0;
			irq_q <= 1'b0;
		end else begin
			if (wr_en && paddr == `ODC_OFF_INT_EN)
				int_en_q <= pwdata[2:0];
			int_stat_q <= (int_stat_q &
				~((wr_en && paddr == `ODC_OFF_INT_CLR) ? pwdata[2:0] : 3'h0)) |
				{ev_abort, ev_done, ev_fail & strap_done_q};
			irq_q <= |(int_stat_q & int_en_q);
		end
	end

	// ======================================================================
	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign current_source = cur_src_q;
	assign target_source = target_q;
	assign target_start = start_q;
	assign secondary_osc_enable = sec_en_q; // RULE_02
	assign phase_input_div = pre_div_q;
	assign vco_output_div = vco_div_q;
	assign feedback_mult = mult_q;
	assign rc_trim = trim_q;
	assign irq = irq_q;

endmodule // odc_top

`default_nettype wire

// ===== dv/odc_top_props.sv
// Port checker for the oscillator control block.
// Assumes a bind onto odc_top and the map header.
`include "odc_map.vh"
`default_nettype none
// =====
// Checker
module odc_top_props (
	input wire sys_clk,
	input wire rst,
	input wire warm_rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire clock_fail_monitor,
	input wire [2:0] current_source,
	input wire [2:0] target_source,
	input wire target_start,
	input wire secondary_osc_enable,
	input wire [5:0] phase_input_div,
	input wire [3:0] vco_output_div,
	input wire [9:0] feedback_mult,
	input wire [5:0] rc_trim
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Completed write; fields land on its edge
	wire wr_ok = psel && penable && pready && pwrite;
	// Unlock stage as seen from the bus; warm reset drops it as in the block
	logic [1:0] key_q;
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			key_q <= 2'd0;
		end else if (warm_rst) begin
			key_q <= 2'd0;
		end else if (wr_ok) begin
			if (paddr != `ODC_OFF_UNLOCK)
				key_q <= 2'd0;
			else if (pwdata[15:0] == `ODC_KEY_FIRST)
				key_q <= 2'd1;
			else if (key_q == 2'd1 && pwdata[15:0] == `ODC_KEY_SECOND)
				key_q <= 2'd2;
			else
				key_q <= 2'd0;
		end
	end
	// Divisor outputs are decoded one cycle after the field lands
	div_pre_a: assert property (wr_ok && paddr == `ODC_OFF_CLK_DIV |-> ##2
		phase_input_div == $past(pwdata[4:0], 2) + 6'd2) else $error("prescaler");
	vco_div_a: assert property (wr_ok && paddr == `ODC_OFF_CLK_DIV |-> ##2
		vco_output_div == ($past(pwdata[7:6], 2) == 2'b11 ? 4'd8 :
		$past(pwdata[7:6], 2) == 2'b00 ? 4'd2 : 4'd4)) else $error("postscaler");
	fb_mult_a: assert property (wr_ok && paddr == `ODC_OFF_PLL_FB |-> ##2
		feedback_mult == $past(pwdata[8:0], 2) + 10'd2) else $error("multiplier");
	trim_val_a: assert property (wr_ok && paddr == `ODC_OFF_RC_TRIM |=>
		rc_trim == $past(pwdata[5:0])) else $error("trim");
	sec_hold_a: assert property ($changed(secondary_osc_enable) |->
		$past(wr_ok && paddr == `ODC_OFF_OSC_CTRL && key_q == 2'd2))
		else $error("enable moved");
	sw_len_a: assert property ($rose(target_start) |-> target_start [*8])
		else $error("switch short");
	sw_done_a: assert property ($fell(target_start) && !$past(clock_fail_monitor) |->
		current_source == target_source) else $error("switch result");
	sw_diff_a: assert property ($rose(target_start) |->
		target_source != current_source) else $error("redundant switch");
	rd_zero_a: assert property (pready && !pwrite && paddr == `ODC_OFF_PLL_FB |->
		prdata[31:9] == 23'h0) else $error("unused bits");
	bad_addr_a: assert property (pready && !pwrite && paddr > 8'h1c |->
		pslverr && prdata == 32'h0) else $error("unmapped");
	c_sw: cover property ($fell(target_start));
	c_err: cover property (pslverr);
	c_clr: cover property (wr_ok && paddr == `ODC_OFF_INT_CLR);
endmodule // odc_top_props
bind odc_top odc_top_props i_odc_top_props (.sys_clk, .rst, .warm_rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .clock_fail_monitor, .current_source,
	.target_source, .target_start, .secondary_osc_enable, .phase_input_div,
	.vco_output_div, .feedback_mult, .rc_trim);
`default_nettype wire

// ===== dv/oscillator_divider_control_test.sv
// Self-checking bench of the oscillator control block.
// Assumes odc_top with the boot source strapped to zero.
`include "odc_map.vh"
`default_nettype none
// =====
// Bench
module oscillator_divider_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst, warm_rst, psel, penable, pwrite, pready, pslverr, er;
	logic clock_fail_monitor, new_source_tick, cpu_interrupt, target_start, irq;
	logic secondary_osc_enable, cpu_clk_en, fast_rc_clk_en;
	logic [7:0] paddr, source_ready;
	logic [31:0] pwdata, prdata, q, v;
	logic [2:0] boot_source, current_source, target_source;
	logic [5:0] phase_input_div, rc_trim;
	logic [3:0] vco_output_div;
	logic [9:0] feedback_mult;
	int num_errors, n_checks, cyc, i, m_div, m_fb, m_tr;
	odc_top i_odc_top (.sys_clk, .rst, .warm_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .boot_source, .clock_fail_monitor, .source_ready,
		.new_source_tick, .cpu_interrupt, .current_source, .target_source, .target_start,
		.secondary_osc_enable, .cpu_clk_en, .fast_rc_clk_en, .phase_input_div,
		.vco_output_div, .feedback_mult, .rc_trim, .irq);
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) num_errors++;
		q = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("prdata", e, q);
	endtask
	// Unlock keys, then one control write
	task automatic osc(input logic [31:0] d);
		apb(1'b1, `ODC_OFF_UNLOCK, `ODC_KEY_FIRST);
		apb(1'b1, `ODC_OFF_UNLOCK, `ODC_KEY_SECOND);
		apb(1'b1, `ODC_OFF_OSC_CTRL, d);
	endtask
	// One-cycle event pulses: tick, fail, interrupt, warm reset
	task automatic pulse(input int k, input int r);
		repeat (r) begin
			@(posedge sys_clk);
			{warm_rst, cpu_interrupt, clock_fail_monitor, new_source_tick} <= 4'(1 << k);
			@(posedge sys_clk);
			{warm_rst, cpu_interrupt, clock_fail_monitor, new_source_tick} <= 4'h0;
		end
	endtask
	// Settle the dividers first; a rate change may finish an old count
	task automatic cnt(input int ec, input int ef);
		int a, b;
		a = 0;
		b = 0;
		repeat (260) @(posedge sys_clk);
		repeat (64) begin
			@(posedge sys_clk);
			a += cpu_clk_en;
			b += fast_rc_clk_en;
		end
		chk("cpu_clk_en", ec, a);
		chk("fast_rc_clk_en", ef, b);
	endtask
	task automatic defaults;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		rd(`ODC_OFF_OSC_CTRL, 32'h0);
		rd(`ODC_OFF_CLK_DIV, 32'h3040);
		rd(`ODC_OFF_PLL_FB, 32'h30);
		rd(`ODC_OFF_RC_TRIM, 32'h0);
		chk("phase_input_div", 2, phase_input_div);
		chk("vco_output_div", 4, vco_output_div);
		chk("feedback_mult", 50, feedback_mult);
	endtask
	task automatic conclude;
		if (num_errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			conclude();
		end
	end
	// Main sequence
	initial begin
		{rst, warm_rst, psel, penable, pwrite, clock_fail_monitor} = 6'h20;
		{new_source_tick, cpu_interrupt, paddr, pwdata, boot_source, source_ready} = '0;
		void'($urandom(63));
		defaults();
		for (i = 0; i < 8; i++) begin
			v = ($urandom & 32'hffff373f) | (i[1:0] << 6);
			m_div = v & 32'hffdf;
			apb(1'b1, `ODC_OFF_CLK_DIV, v);
			v = $urandom;
			m_fb = v & 32'h1ff;
			apb(1'b1, `ODC_OFF_PLL_FB, v);
			v = $urandom;
			m_tr = v & 32'h3f;
			apb(1'b1, `ODC_OFF_RC_TRIM, v);
			rd(`ODC_OFF_CLK_DIV, m_div);
			rd(`ODC_OFF_PLL_FB, m_fb);
			rd(`ODC_OFF_RC_TRIM, m_tr);
			chk("phase_input_div", (m_div & 32'h1f) + 2, phase_input_div);
			chk("vco_output_div", i % 4 == 3 ? 8 : i % 4 == 0 ? 2 : 4, vco_output_div);
			chk("feedback_mult", m_fb + 2, feedback_mult);
			chk("rc_trim", m_tr, rc_trim);
		end
		apb(1'b1, `ODC_OFF_CLK_DIV, 32'h3a00);
		pulse(2, 1);
		rd(`ODC_OFF_CLK_DIV, 32'h3a00);
		cnt(8, 16);
		apb(1'b1, `ODC_OFF_CLK_DIV, 32'hba00);
		pulse(2, 1);
		rd(`ODC_OFF_CLK_DIV, 32'hb200);
		cnt(64, 16);
		apb(1'b1, `ODC_OFF_OSC_CTRL, 32'h2);
		rd(`ODC_OFF_OSC_CTRL, 32'h0);
		osc(32'h2);
		rd(`ODC_OFF_OSC_CTRL, 32'h2);
		chk("secondary_osc_enable", 1, secondary_osc_enable);
		osc(32'h3);
		rd(`ODC_OFF_OSC_CTRL, 32'h2);
		rd(`ODC_OFF_INT_STAT, 32'h4);
		chk("irq", 0, irq);
		apb(1'b1, `ODC_OFF_INT_CLR, 32'h7);
		apb(1'b1, `ODC_OFF_INT_EN, 32'h7);
		osc(32'h203);
		rd(`ODC_OFF_OSC_CTRL, 32'h203);
		chk("target_source", 2, target_source);
		source_ready <= 8'h04;
		pulse(0, 9);
		chk("current_source", 0, current_source);
		pulse(0, 1);
		rd(`ODC_OFF_OSC_CTRL, 32'h2202);
		rd(`ODC_OFF_INT_STAT, 32'h2);
		chk("irq", 1, irq);
		apb(1'b1, `ODC_OFF_INT_CLR, 32'h7);
		rd(`ODC_OFF_INT_STAT, 32'h0);
		chk("irq", 0, irq);
		pulse(1, 1);
		rd(`ODC_OFF_OSC_CTRL, 32'h20a);
		rd(`ODC_OFF_INT_STAT, 32'h1);
		osc(32'h20a);
		rd(`ODC_OFF_OSC_CTRL, 32'h20a);
		osc(32'h202);
		rd(`ODC_OFF_OSC_CTRL, 32'h202);
		osc(32'h303);
		rd(`ODC_OFF_OSC_CTRL, 32'h303);
		source_ready <= 8'h0c;
		pulse(0, 10);
		rd(`ODC_OFF_OSC_CTRL, 32'h3302);
		pulse(1, 1);
		rd(`ODC_OFF_OSC_CTRL, 32'h130a);
		chk("current_source", 1, current_source);
		apb(1'b0, 8'h20, 32'h0);
		chk("pslverr", 1, er);
		pulse(3, 1);
		rd(`ODC_OFF_CLK_DIV, 32'hb200);
		rd(`ODC_OFF_OSC_CTRL, 32'h130a);
		defaults();
		conclude();
	end
endmodule // oscillator_divider_control_test
`default_nettype wire
